// ==== rtl/pbcs_regs.svh ====
`ifndef PBCS_REGS_SVH
`define PBCS_REGS_SVH
// Register offsets (byte addresses)
`define PBCS_OFF_CSR        12'h240
`define PBCS_OFF_IRQ_STAT   12'h244
`define PBCS_OFF_IRQ_MASK   12'h248
`define PBCS_OFF_EVENT      12'h24C
// Field positions
`define PBCS_SPLIT_SEL_LSB  24
`define PBCS_SPLIT_SEL_MSB  26
`define PBCS_SPLIT_TEST_BIT 22
`define PBCS_CFG_TEST_BIT   21
`define PBCS_WIDE_QUAL_BIT  20
`define PBCS_DT_TEST_BIT    19
`define PBCS_RETRY_TEST_BIT 18
`define PBCS_RETRY_EN_BIT   17
`define PBCS_BYTE_GAP_BIT   16
`define PBCS_SPLIT_ERR_BIT  10
`define PBCS_DT_ERR_BIT     9
`define PBCS_RETRY_ERR_BIT  8
`define PBCS_STRAP_MSB      6
`define PBCS_CTRL_MASK      32'h077F0000
`define PBCS_ERR_MASK       32'h00000700
// Reset values
`define PBCS_SPLIT_SEL_RST  3'h7
// Timing: microsecond base and counts
`define PBCS_CLK_MHZ        100
`define PBCS_SPLIT_BASE_US  16
`define PBCS_SRT_TEST_CYC   32'd22
`define PBCS_DT_TEST_CYC    32'd160
`define PBCS_DT_NORM_CYC    32'd32768
`define PBCS_RETRY_TEST     32'd16
`define PBCS_RETRY_NORM     32'd16777216
`endif

// ==== rtl/pbcs_pkg.sv ====
package pbcs_pkg;
	typedef logic [2:0] pbcs_split_sel_t;
	typedef enum logic [1:0] {PBCS_RESP_OKAY = 2'h0, PBCS_RESP_SLVERR = 2'h2} pbcs_resp_t;
	typedef enum {PBCS_M_IDLE, PBCS_M_BUSY} pbcs_mst_t;
endpackage

// ==== rtl/pbcs_if.sv ====
interface pbcs_if;
	logic        local_reset_in_n;
	logic        req64_n;
	logic        m66en;
	logic        frame_n;
	logic        irdy_n;
	logic        devsel_n;
	logic        stop_n;
	logic        trdy_n;
	logic        split_resp_pending;
	logic        split_resp_done;
	logic        delayed_txn_pending;
	logic        delayed_txn_done;
	logic        retry_seen;
	logic        retry_cycle_ok;
	logic        byte_gap_seen;
	logic        split_resp_timeout_test;
	logic        config_cycle_test_mode;
	logic        ignore_wide_request_qual;
	logic        stop_on_byte_gaps;
	logic        retry_abort;
	logic        split_resp_timeout;
	logic        delayed_txn_timeout;
	logic        wide_bus_64;
	logic        single_beat_only;
	modport dev (
		input  local_reset_in_n, req64_n, m66en, frame_n, irdy_n, devsel_n, stop_n, trdy_n,
		input  split_resp_pending, split_resp_done, delayed_txn_pending, delayed_txn_done,
		input  retry_seen, retry_cycle_ok, byte_gap_seen,
		output split_resp_timeout_test, config_cycle_test_mode, ignore_wide_request_qual,
		output stop_on_byte_gaps, retry_abort, split_resp_timeout, delayed_txn_timeout,
		output wide_bus_64, single_beat_only
	);
	modport agent (
		output local_reset_in_n, req64_n, m66en, frame_n, irdy_n, devsel_n, stop_n, trdy_n,
		output split_resp_pending, split_resp_done, delayed_txn_pending, delayed_txn_done,
		output retry_seen, retry_cycle_ok, byte_gap_seen,
		input  split_resp_timeout_test, config_cycle_test_mode, ignore_wide_request_qual,
		input  stop_on_byte_gaps, retry_abort, split_resp_timeout, delayed_txn_timeout,
		input  wide_bus_64, single_beat_only
	);
endinterface

// ==== rtl/pbcs_timer.sv ====
// Counts enabled cycles up to a limit; restarts whenever run drops
module pbcs_timer #(
	parameter int W = 32
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         run,
	input  wire logic [W-1:0] limit,
	input  wire logic         tick,
	output logic              expired
);
	logic [W-1:0] cnt_r;

	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			cnt_r <= '0;
		end else if (tick && cnt_r < limit) begin
			cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
		end
	end

	// One-cycle pulse when the limit is reached
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			expired <= 1'b0;
		end else begin
			expired <= run && tick && (cnt_r + {{(W-1){1'b0}}, 1'b1} == limit);
		end
	end
endmodule

// ==== rtl/pbcs_agent.sv ====
`include "pbcs_regs.svh"
// Far-side agent: drives straps and transaction events, issues register orders over AXI4-Lite
module pbcs_agent (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	pbcs_if.agent            link,
	input  wire logic [6:0]  strap_levels,
	input  wire logic        local_reset_req,
	input  wire logic [4:0]  event_drive,
	input  wire logic [1:0]  done_drive,
	input  wire logic        retry_ok_drive,
	input  wire logic        cmd_valid,
	input  wire logic        cmd_write,
	input  wire logic [11:0] cmd_addr,
	input  wire logic [31:0] cmd_wdata,
	output logic             cmd_ready,
	output logic [31:0]      cmd_rdata,
	output logic [1:0]       cmd_resp,
	output logic             cmd_done,
	output logic [11:0]      m_awaddr,
	output logic             m_awvalid,
	input  wire logic        m_awready,
	output logic [31:0]      m_wdata,
	output logic [3:0]       m_wstrb,
	output logic             m_wvalid,
	input  wire logic        m_wready,
	input  wire logic [1:0]  m_bresp,
	input  wire logic        m_bvalid,
	output logic             m_bready,
	output logic [11:0]      m_araddr,
	output logic             m_arvalid,
	input  wire logic        m_arready,
	input  wire logic [31:0] m_rdata,
	input  wire logic [1:0]  m_rresp,
	input  wire logic        m_rvalid,
	output logic             m_rready
);
	pbcs_pkg::pbcs_mst_t st_r;

	// Straps and events from registers so the device sees clean levels
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			link.local_reset_in_n    <= 1'b0;
			{link.req64_n, link.m66en, link.frame_n, link.irdy_n, link.devsel_n, link.stop_n,
				link.trdy_n} <= 7'h7F;
			{link.split_resp_pending, link.delayed_txn_pending, link.retry_seen, link.byte_gap_seen,
				link.retry_cycle_ok} <= 5'h00;
			{link.split_resp_done, link.delayed_txn_done} <= 2'h0;
		end else begin
			link.local_reset_in_n    <= !local_reset_req;
			{link.req64_n, link.m66en, link.frame_n, link.irdy_n, link.devsel_n, link.stop_n,
				link.trdy_n} <= strap_levels;
			{link.split_resp_pending, link.delayed_txn_pending, link.retry_seen, link.byte_gap_seen,
				link.retry_cycle_ok} <= {event_drive[4:1], retry_ok_drive};
			{link.split_resp_done, link.delayed_txn_done} <= done_drive;
		end
	end

	assign cmd_ready = (st_r == pbcs_pkg::PBCS_M_IDLE);
	assign m_wstrb   = 4'hF;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r      <= pbcs_pkg::PBCS_M_IDLE;
			m_awvalid <= 1'b0;
			m_wvalid  <= 1'b0;
			m_arvalid <= 1'b0;
			m_bready  <= 1'b0;
			m_rready  <= 1'b0;
			m_awaddr  <= 12'h000;
			m_araddr  <= 12'h000;
			m_wdata   <= 32'h00000000;
			cmd_rdata <= 32'h00000000;
			cmd_resp  <= 2'h0;
			cmd_done  <= 1'b0;
		end else begin
			cmd_done <= 1'b0;
			unique case (st_r)
				pbcs_pkg::PBCS_M_IDLE: begin
					if (cmd_valid) begin
						st_r <= pbcs_pkg::PBCS_M_BUSY;
						if (cmd_write) begin
							m_awaddr  <= cmd_addr;
							m_wdata   <= cmd_wdata;
							m_awvalid <= 1'b1;
							m_wvalid  <= 1'b1;
							m_bready  <= 1'b1;
						end else begin
							m_araddr  <= cmd_addr;
							m_arvalid <= 1'b1;
							m_rready  <= 1'b1;
						end
					end
				end
				pbcs_pkg::PBCS_M_BUSY: begin
					if (m_awready) m_awvalid <= 1'b0;
					if (m_wready) m_wvalid <= 1'b0;
					if (m_arready) m_arvalid <= 1'b0;
					if (m_bvalid && m_bready) begin
						m_bready <= 1'b0;
						cmd_resp <= m_bresp;
						cmd_done <= 1'b1;
						st_r     <= pbcs_pkg::PBCS_M_IDLE;
					end
					if (m_rvalid && m_rready) begin
						m_rready  <= 1'b0;
						cmd_rdata <= m_rdata;
						cmd_resp  <= m_rresp;
						cmd_done  <= 1'b1;
						st_r      <= pbcs_pkg::PBCS_M_IDLE;
					end
				end
			endcase
		end
	end
endmodule

// ==== rtl/pbcs_device.sv ====
// The AXI4-Lite register port was left to the implementer.
`include "pbcs_regs.svh"
// Contract
// - Latch bus straps at local reset release
// - Split timeout code selects 16..1024 us
// - Software sets split timeout above global
// - Test bit shortens split timeout, single beat
// - Config test mode for decoder 7
// - Software keeps wide request bit clear
// - Delayed timeout 160 or 2^15 clocks
// - Retry limit enable aborts after limit
// - Retry limit 16 or 2^24
// - Software keeps retry test bit clear
// - Stop on byte gaps in conventional mode
// - Sticky split timeout flag, write one clears
// - Sticky delayed timeout flag, write one clears
// - Sticky retry flag only when enabled
// - Wide request strap one means 32-bit
// - Fast clock strap records M66EN level
// - Bits 4..0 hold bus strap levels
module pbcs_device #(
	parameter int DT_NORM_CYC = 32768,
	parameter int RETRY_NORM  = 16777216,
	parameter int US_CYC      = 100
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	pbcs_if.dev              link,
	input  wire logic [11:0] s_awaddr,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	output logic [1:0]       s_bresp,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	input  wire logic [11:0] s_araddr,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	output logic             s_rvalid,
	input  wire logic        s_rready,
	output logic             irq
);
	logic [31:0] ctrl_r;
	logic [2:0]  err_r;
	logic [2:0]  mask_r;
	logic [6:0]  strap_r;
	logic [7:0]  sync1_r;
	logic [7:0]  sync2_r;
	logic        lrst_d_r;
	logic        aw_hit_r;
	logic        w_hit_r;
	logic [11:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;
	logic [6:0]  us_cnt_r;
	logic        us_tick;
	logic        srt_run;
	logic        wr_fire;
	logic [31:0] wbe;
	logic [2:0]  err_set;
	logic [2:0]  err_clr;
	logic        srt_exp;
	logic        dt_exp;
	logic        rt_exp;
	logic [31:0] srt_lim;
	logic [31:0] dt_lim;
	logic [31:0] rt_lim;
	logic [31:0] csr_view;

	// Local reset and strap pins double synchronised before use; event inputs used directly
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_r <= 8'h00;
			sync2_r <= 8'h00;
		end else begin
			sync1_r <= {link.local_reset_in_n, link.req64_n, link.m66en, link.frame_n, link.irdy_n,
				link.devsel_n, link.stop_n, link.trdy_n};
			sync2_r <= sync1_r;
		end
	end

	// Straps caught at the local reset rising edge; held otherwise
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lrst_d_r <= 1'b0;
			strap_r  <= 7'h00;
		end else begin
			lrst_d_r <= sync2_r[7];
			if (sync2_r[7] && !lrst_d_r)
				strap_r <= sync2_r[6:0];
		end
	end

	// Test bit overrides the disable code
	assign srt_run = link.split_resp_pending &&
		(ctrl_r[`PBCS_SPLIT_SEL_MSB:`PBCS_SPLIT_SEL_LSB] != 3'h7 || ctrl_r[`PBCS_SPLIT_TEST_BIT]);

	// Microsecond tick restarted per split, so no partial first period
	assign us_tick = (us_cnt_r == 7'(US_CYC - 1));
	always_ff @(posedge aclk) begin
		if (!aresetn || us_tick || !srt_run) us_cnt_r <= 7'h00;
		else us_cnt_r <= us_cnt_r + 7'h01;
	end

	// Split limit: base 16 us doubled per code; test mode counts cycles
	assign srt_lim = ctrl_r[`PBCS_SPLIT_TEST_BIT] ? `PBCS_SRT_TEST_CYC
		: (32'(`PBCS_SPLIT_BASE_US) << ctrl_r[`PBCS_SPLIT_SEL_MSB:`PBCS_SPLIT_SEL_LSB]);
	assign dt_lim = ctrl_r[`PBCS_DT_TEST_BIT] ? `PBCS_DT_TEST_CYC : 32'(DT_NORM_CYC);
	assign rt_lim = ctrl_r[`PBCS_RETRY_TEST_BIT] ? `PBCS_RETRY_TEST : 32'(RETRY_NORM);

	pbcs_timer #(.W(32)) u_srt (
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (srt_run),
		.limit   (srt_lim),
		.tick    (ctrl_r[`PBCS_SPLIT_TEST_BIT] ? 1'b1 : us_tick),
		.expired (srt_exp)
	);
	pbcs_timer #(.W(32)) u_dt (
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (link.delayed_txn_pending),
		.limit   (dt_lim),
		.tick    (1'b1),
		.expired (dt_exp)
	);
	// Counts retries in a row; a clean cycle restarts it
	pbcs_timer #(.W(32)) u_rt (
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (ctrl_r[`PBCS_RETRY_EN_BIT] && !link.retry_cycle_ok),
		.limit   (rt_lim),
		.tick    (link.retry_seen),
		.expired (rt_exp)
	);

	assign link.split_resp_timeout      = srt_exp;
	assign link.delayed_txn_timeout     = dt_exp;
	assign link.retry_abort             = rt_exp && ctrl_r[`PBCS_RETRY_EN_BIT];
	assign link.split_resp_timeout_test = ctrl_r[`PBCS_SPLIT_TEST_BIT];
	assign link.config_cycle_test_mode  = ctrl_r[`PBCS_CFG_TEST_BIT];
	assign link.single_beat_only        = ctrl_r[`PBCS_SPLIT_TEST_BIT] | ctrl_r[`PBCS_CFG_TEST_BIT];
	assign link.ignore_wide_request_qual = ctrl_r[`PBCS_WIDE_QUAL_BIT];
	assign link.stop_on_byte_gaps       = ctrl_r[`PBCS_BYTE_GAP_BIT];
	assign link.wide_bus_64             = !strap_r[6];

	// AXI4-Lite write: address and data taken in either order
	assign s_awready = !aw_hit_r && !s_bvalid;
	assign s_wready  = !w_hit_r && !s_bvalid;
	assign wr_fire   = aw_hit_r && w_hit_r;
	assign wbe       = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hit_r <= 1'b0;
			w_hit_r  <= 1'b0;
			awaddr_r <= 12'h000;
			wdata_r  <= 32'h00000000;
			wstrb_r  <= 4'h0;
			s_bvalid <= 1'b0;
			s_bresp  <= 2'h0;
		end else begin
			if (s_awvalid && s_awready) begin
				aw_hit_r <= 1'b1;
				awaddr_r <= s_awaddr;
			end
			if (s_wvalid && s_wready) begin
				w_hit_r <= 1'b1;
				wdata_r <= s_wdata;
				wstrb_r <= s_wstrb;
			end
			if (wr_fire) begin
				aw_hit_r <= 1'b0;
				w_hit_r  <= 1'b0;
				s_bvalid <= 1'b1;
				s_bresp  <= (awaddr_r == `PBCS_OFF_CSR || awaddr_r == `PBCS_OFF_IRQ_STAT ||
					awaddr_r == `PBCS_OFF_IRQ_MASK) ? pbcs_pkg::PBCS_RESP_OKAY : pbcs_pkg::PBCS_RESP_SLVERR;
			end else if (s_bvalid && s_bready) begin
				s_bvalid <= 1'b0;
			end
		end
	end

	// Control bits; only writable fields change
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= 32'h00000000;
			ctrl_r[`PBCS_SPLIT_SEL_MSB:`PBCS_SPLIT_SEL_LSB] <= `PBCS_SPLIT_SEL_RST;
		end else if (wr_fire && awaddr_r == `PBCS_OFF_CSR) begin
			ctrl_r <= (ctrl_r & ~(wbe & `PBCS_CTRL_MASK)) | (wdata_r & wbe & `PBCS_CTRL_MASK);
		end
	end

	// Error flags: set beats clear in the same cycle
	assign err_set = {srt_exp, dt_exp, rt_exp && ctrl_r[`PBCS_RETRY_EN_BIT]};
	always_comb begin
		err_clr = 3'h0;
		if (wr_fire && (awaddr_r == `PBCS_OFF_CSR || awaddr_r == `PBCS_OFF_IRQ_STAT) && wstrb_r[1])
			err_clr = wdata_r[`PBCS_SPLIT_ERR_BIT:`PBCS_RETRY_ERR_BIT];
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) err_r <= 3'h0;
		else err_r <= (err_r & ~err_clr) | err_set;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) mask_r <= 3'h0;
		else if (wr_fire && awaddr_r == `PBCS_OFF_IRQ_MASK && wstrb_r[1])
			mask_r <= wdata_r[`PBCS_SPLIT_ERR_BIT:`PBCS_RETRY_ERR_BIT];
	end

	assign irq = |(err_r & mask_r);

	// Read channel; reserved bits read zero
	assign csr_view  = ctrl_r | {21'h000000, err_r, 1'b0, strap_r};
	assign s_arready = !s_rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_rvalid <= 1'b0;
			s_rdata  <= 32'h00000000;
			s_rresp  <= 2'h0;
		end else if (s_arvalid && s_arready) begin
			s_rvalid <= 1'b1;
			s_rresp  <= pbcs_pkg::PBCS_RESP_OKAY;
			unique case (s_araddr)
				`PBCS_OFF_CSR:      s_rdata <= csr_view;
				`PBCS_OFF_IRQ_STAT: s_rdata <= {21'h000000, err_r, 8'h00};
				`PBCS_OFF_IRQ_MASK: s_rdata <= {21'h000000, mask_r, 8'h00};
				default: begin
					s_rdata <= 32'h00000000;
					s_rresp <= pbcs_pkg::PBCS_RESP_SLVERR;
				end
			endcase
		end else if (s_rvalid && s_rready) begin
			s_rvalid <= 1'b0;
		end
	end
endmodule

// ==== tb/pbcs_props.sv ====
module pbcs_props #(
	parameter int DT_NORM_CYC = 200
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic local_reset_in_n,
	input wire logic split_resp_pending,
	input wire logic delayed_txn_pending,
	input wire logic retry_seen,
	input wire logic retry_cycle_ok,
	input wire logic split_resp_timeout_test,
	input wire logic config_cycle_test_mode,
	input wire logic retry_abort,
	input wire logic split_resp_timeout,
	input wire logic delayed_txn_timeout,
	input wire logic wide_bus_64,
	input wire logic single_beat_only
);
	logic [15:0] dt_cnt_r;
	logic [15:0] sr_cnt_r;
	logic [7:0]  rt_cnt_r;
	logic [3:0]  lr_since_r;
	logic        lr_prev_r;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Run lengths restart on each timeout so a refire is timed afresh
	always_ff @(posedge aclk) begin
		if (!aresetn || !delayed_txn_pending || delayed_txn_timeout)
			dt_cnt_r <= '0;
		else
			dt_cnt_r <= dt_cnt_r + 16'h1;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn || !split_resp_pending || split_resp_timeout)
			sr_cnt_r <= '0;
		else
			sr_cnt_r <= sr_cnt_r + 16'h1;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn || retry_cycle_ok)
			rt_cnt_r <= '0;
		else if (retry_seen && rt_cnt_r != 8'hFF)
			rt_cnt_r <= rt_cnt_r + 8'h1;
	end
	always_ff @(posedge aclk) begin
		lr_prev_r <= aresetn && local_reset_in_n;
		if (!aresetn)
			lr_since_r <= 4'hF;
		else if (local_reset_in_n && !lr_prev_r)
			lr_since_r <= 4'h0;
		else if (lr_since_r != 4'hF)
			lr_since_r <= lr_since_r + 4'h1;
	end
	chk_single_beat: assert property (single_beat_only == (split_resp_timeout_test || config_cycle_test_mode))
		else $error("single beat level wrong");
	chk_dt_early: assert property (delayed_txn_timeout |-> dt_cnt_r >= 16'd158)
		else $error("delayed timeout too early");
	chk_dt_late: assert property (dt_cnt_r <= DT_NORM_CYC + 3)
		else $error("delayed timeout missing");
	chk_dt_pulse: assert property (delayed_txn_timeout |=> !delayed_txn_timeout)
		else $error("delayed timeout pulse long");
	chk_sr_early: assert property (split_resp_timeout |-> sr_cnt_r >= 16'd21)
		else $error("split timeout too early");
	chk_sr_pulse: assert property (split_resp_timeout |=> !split_resp_timeout)
		else $error("split timeout pulse long");
	chk_retry_floor: assert property (retry_abort |-> rt_cnt_r >= 8'd15)
		else $error("retry abort too early");
	chk_strap_settle: assert property ($changed(wide_bus_64) |-> lr_since_r <= 4'h5)
		else $error("width strap moved");
	cover property (delayed_txn_timeout);
	cover property (split_resp_timeout);
	cover property (retry_abort);
endmodule

// ==== tb/tb_pbcs_device.sv ====
`include "pbcs_regs.svh"
module tb_pbcs_device;
	timeunit 1ns;
	timeprecision 1ns;
	logic        aclk = 0, aresetn = 0, local_reset_req = 0, retry_ok_drive = 0;
	logic [6:0]  strap_levels = '0;
	logic [4:0]  event_drive = '0;
	logic        cmd_valid = 0, cmd_write = 0;
	logic [11:0] cmd_addr = '0;
	logic [31:0] cmd_wdata = '0, q, d;
	logic [1:0]  r;
	wire         cmd_ready, cmd_done, awv, awr, wv, wr_r, bv, br, arv, arr, rv, rr, irq;
	wire  [31:0] cmd_rdata, wd, rdat;
	wire  [11:0] awa, ara;
	wire  [3:0]  ws;
	wire  [1:0]  cmd_resp, bre, rre;
	int          err_count = 0, n_tests = 0, cyc = 0, n, i, lim, aborts = 0, a0;
	pbcs_if link();
	pbcs_agent pbcs_agent_i (.aclk, .aresetn, .link(link.agent), .strap_levels, .local_reset_req, .event_drive,
		.done_drive(2'h0), .retry_ok_drive, .cmd_valid, .cmd_write, .cmd_addr, .cmd_wdata, .cmd_ready, .cmd_rdata,
		.cmd_resp, .cmd_done, .m_awaddr(awa), .m_awvalid(awv), .m_awready(awr), .m_wdata(wd), .m_wstrb(ws),
		.m_wvalid(wv), .m_wready(wr_r), .m_bresp(bre), .m_bvalid(bv), .m_bready(br), .m_araddr(ara), .m_arvalid(arv),
		.m_arready(arr), .m_rdata(rdat), .m_rresp(rre), .m_rvalid(rv), .m_rready(rr));
	pbcs_device #(.DT_NORM_CYC(200), .RETRY_NORM(20), .US_CYC(4)) pbcs_device_i (.aclk, .aresetn, .link(link.dev),
		.s_awaddr(awa), .s_awvalid(awv), .s_awready(awr), .s_wdata(wd), .s_wstrb(ws), .s_wvalid(wv), .s_wready(wr_r),
		.s_bresp(bre), .s_bvalid(bv), .s_bready(br), .s_araddr(ara), .s_arvalid(arv), .s_arready(arr), .s_rdata(rdat),
		.s_rresp(rre), .s_rvalid(rv), .s_rready(rr), .irq);
	pbcs_props #(.DT_NORM_CYC(200)) pbcs_props_i (.aclk, .aresetn, .local_reset_in_n(link.local_reset_in_n),
		.split_resp_pending(link.split_resp_pending), .delayed_txn_pending(link.delayed_txn_pending),
		.retry_seen(link.retry_seen), .retry_cycle_ok(link.retry_cycle_ok),
		.split_resp_timeout_test(link.split_resp_timeout_test), .config_cycle_test_mode(link.config_cycle_test_mode),
		.retry_abort(link.retry_abort), .split_resp_timeout(link.split_resp_timeout),
		.delayed_txn_timeout(link.delayed_txn_timeout), .wide_bus_64(link.wide_bus_64),
		.single_beat_only(link.single_beat_only));
	wire [2:0] evs = {link.retry_abort, link.delayed_txn_timeout, link.split_resp_timeout};
	task end_sim;
		$display("errors %0d tests %0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	always #5 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc++;
		if (link.retry_abort === 1'b1)
			aborts++;
		if (cyc == 60000) begin
			err_count++;
			$display("unexpected %0t hang", $time);
			end_sim();
		end
	end
	task chk_word(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %0t word %h not %h", $time, got, exp);
		end
	endtask
	task chk_cnt(input int got, input int lo, input int hi);
		n_tests++;
		if (got < lo || got > hi) begin
			err_count++;
			$display("unexpected %0t count %0d not %0d..%0d", $time, got, lo, hi);
		end
	endtask
	// Agent command port: request held until taken, answer sampled after the edge
	task acc(input logic w, input logic [11:0] a, input logic [31:0] dat);
		@(posedge aclk);
		cmd_valid <= 1;
		cmd_write <= w;
		cmd_addr <= a;
		cmd_wdata <= dat;
		@(negedge aclk);
		while (cmd_ready !== 1'b1)
			@(negedge aclk);
		@(posedge aclk);
		cmd_valid <= 0;
		do begin
			@(posedge aclk);
			#1;
		end while (cmd_done !== 1'b1);
		q = cmd_rdata;
		r = cmd_resp;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
		acc(0, a, 32'h0);
		chk_word(q & m, exp);
	endtask
	// Holds one event level until its pulse or the limit, then releases it
	task run_ev(input logic [4:0] ev, input int sel, input int lmt);
		@(posedge aclk);
		event_drive <= ev;
		n = 0;
		do begin
			@(posedge aclk);
			#1;
			n++;
		end while (evs[sel] !== 1'b1 && n < lmt);
		@(posedge aclk);
		event_drive <= 5'h0;
		repeat (4) @(posedge aclk);
	endtask
	task retries(input int k);
		repeat (k) begin
			@(posedge aclk);
			event_drive <= 5'h04;
			@(posedge aclk);
			event_drive <= 5'h00;
		end
		repeat (4) @(posedge aclk);
	endtask
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1;
		rd(`PBCS_OFF_CSR, 32'h07000000, 32'hFFFFFF80);
		for (i = 0; i < 2; i++) begin
			@(posedge aclk);
			strap_levels <= i ? 7'h2A : 7'h55;
			local_reset_req <= 1;
			repeat (4) @(posedge aclk);
			local_reset_req <= 0;
			repeat (8) @(posedge aclk);
			strap_levels <= i ? 7'h55 : 7'h2A;
			rd(`PBCS_OFF_CSR, i ? 32'h0700002A : 32'h07000055, 32'hFFFFFFFF);
			chk_word({31'h0, link.wide_bus_64}, i);
		end
		for (i = 0; i < 3; i++) begin
			d = i == 0 ? 32'hFFFFFFFF : (i == 1 ? 32'h00200000 : 32'h0); // Ends with qual bit clear
			acc(1, `PBCS_OFF_CSR, d);
			rd(`PBCS_OFF_CSR, (d & `PBCS_CTRL_MASK) | 32'h2A, 32'hFFFFFFFF);
			chk_word({link.split_resp_timeout_test, link.config_cycle_test_mode, link.ignore_wide_request_qual,
				link.stop_on_byte_gaps, link.single_beat_only}, {d[22:20], d[16], d[22] | d[21]});
		end
		acc(1, `PBCS_OFF_CSR, 32'h07080000);
		run_ev(5'h08, 1, 400);
		chk_cnt(n, 160, 166);
		acc(1, `PBCS_OFF_CSR, 32'h07000000);
		rd(`PBCS_OFF_CSR, 32'h00000200, 32'h00000700);
		run_ev(5'h08, 1, 400);
		chk_cnt(n, 200, 206);
		rd(`PBCS_OFF_IRQ_STAT, 32'h00000200, 32'h00000700);
		chk_word({31'h0, irq}, 32'h0);
		acc(1, `PBCS_OFF_IRQ_MASK, 32'h00000700);
		chk_word({30'h0, r}, 32'h0);
		chk_word({31'h0, irq}, 32'h1);
		acc(1, `PBCS_OFF_CSR, 32'h07000200);
		chk_word({31'h0, irq}, 32'h0);
		for (i = 0; i < 9; i++) begin
			d = i < 8 ? {5'h0, i[2:0], 24'h0} : 32'h07400000; // No global timeout on this bench
			lim = i < 7 ? 64 << i : (i == 7 ? 300 : 22);
			acc(1, `PBCS_OFF_CSR, d);
			run_ev(5'h10, 0, lim + 8);
			chk_cnt(n, lim, i == 7 ? 308 : lim + 6);
			rd(`PBCS_OFF_CSR, i == 7 ? 32'h0 : 32'h00000400, 32'h00000400);
			acc(1, `PBCS_OFF_CSR, d | 32'h00000400);
		end
		for (i = 0; i < 3; i++) begin
			d = i == 0 ? 32'h07060000 : (i == 1 ? 32'h07020000 : 32'h07000000);
			lim = i == 0 ? 16 : (i == 1 ? 20 : 26);
			acc(1, `PBCS_OFF_CSR, d);
			@(posedge aclk);
			retry_ok_drive <= 1;
			@(posedge aclk);
			retry_ok_drive <= 0;
			repeat (3) @(posedge aclk);
			a0 = aborts;
			retries(lim - 1);
			chk_cnt(aborts - a0, 0, 0);
			retries(1);
			chk_cnt(aborts - a0, i < 2, i < 2);
			rd(`PBCS_OFF_CSR, i < 2 ? 32'h00000100 : 32'h0, 32'h00000100);
			acc(1, `PBCS_OFF_CSR, d | 32'h00000100); // Last pass leaves retry test clear
		end
		acc(0, 12'h300, 32'h0);
		chk_word({30'h0, r}, 32'h2);
		acc(1, `PBCS_OFF_EVENT, 32'h0);
		chk_word({30'h0, r}, 32'h2);
		end_sim();
	end
endmodule
